/* File: logic/flash_control_registers.sv */
// Purpose: Clock divider, options and key configuration registers of
//          the program memory, reached over AHB-Lite.
// Assumes: Array write, blank check and nonvolatile byte inputs come
//          from logic on CLOCK; nonvolatile bytes are stable at reset.
// Notes:   Zero-wait slave; read data is latched in the address phase.
`timescale 1ns/1ps
module flash_control_registers
  import flash_ctl_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RST,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic [31:0]      HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic [7:0]  NV_OPTION_BYTE,
  input  wire logic [7:0]  NV_PROTECT_BYTE,
  input  wire logic [63:0] NV_UNLOCK_KEY,
  input  wire logic        ARRAY_WR,
  input  wire logic [15:0] ARRAY_ADDR,
  input  wire logic [7:0]  ARRAY_DATA,
  input  wire logic        ARRAY_SRC_SECURE,
  input  wire logic        ARRAY_SRC_DEBUG,
  input  wire logic        BLANK_CHECK_PASS,
  input  wire logic        MEM_SRC_UNSECURED,
  output logic             CMD_START,
  output logic             PGM_ERASE_ALLOW,
  output logic             NV_TICK,
  output logic             SECURE,
  output logic             MEM_BLOCK,
  output logic             VECTOR_REDIRECT_DISABLE,
  output logic [7:0]       PROTECTION
);

  // ***************************************************************
  // State
  // ***************************************************************
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic        loaded;
  logic        prescale;
  logic [5:0]  ratio;
  logic        key_en;
  logic        redir_dis;
  logic [1:0]  sec;
  logic        key_sel;
  logic        acc_err;
  key_state_t  key_state;
  logic [3:0]  key_idx;
  logic        next_wr_pend;
  logic [7:0]  next_wr_addr;
  logic        next_loaded;
  logic        next_prescale;
  logic [5:0]  next_ratio;
  logic [1:0]  next_sec;
  logic        next_key_sel;
  logic        next_acc_err;
  key_state_t  next_key_state;
  logic [3:0]  next_key_idx;
  logic        next_cmd_start;
  logic        next_secure;
  logic        next_mem_block;
  logic [31:0] next_hrdata;
  logic        in_key_window;
  logic        key_src_ok;
  logic        addr_phase;

  // Picks one stored key byte; byte 0 sits at the window base.
  function automatic logic [7:0] key_byte(input logic [63:0] key,
                                          input logic [2:0]  idx);
    key_byte = key[idx*8 +: 8];
  endfunction

  // Register read mux shared by the bus read path.
  function automatic logic [31:0] read_word(input logic [7:0] a);
    read_word = 32'h0000_0000;
    case (a)
      ADDR_CLOCK_DIVIDER: read_word[7:0] = {loaded, prescale, ratio};
      ADDR_OPTIONS:       read_word[7:0] = {key_en, redir_dis, 4'h0, sec};
      ADDR_CONFIGURATION: read_word[CNFG_KEY_SEL_BIT] = key_sel;
      ADDR_PROTECTION:    read_word[7:0] = PROTECTION;
      ADDR_STATUS: begin
        read_word[STAT_ERR_BIT]    = acc_err;
        read_word[STAT_SECURE_BIT] = SECURE;
      end
      default:            read_word = 32'h0000_0000;
    endcase
  endfunction

  // ***************************************************************
  // Bus decode
  // ***************************************************************
  // A transfer is taken when the one slave sees HREADY high; HSIZE is
  // not checked because only whole-word transfers are issued.
  assign addr_phase    = HSEL && HTRANS[1] && HREADY;
  assign in_key_window = ARRAY_ADDR >= KEY_BASE_ADDR &&
                         ARRAY_ADDR <= KEY_LAST_ADDR;
  // Debug-port writes never reach the comparator, even from a
  // secure image, so a probe cannot brute-force the key.
  assign key_src_ok    = ARRAY_SRC_SECURE && !ARRAY_SRC_DEBUG;

  // ***************************************************************
  // Next-state logic
  // ***************************************************************
  always_comb begin
    next_wr_pend   = addr_phase && HWRITE;
    next_wr_addr   = HADDR[7:0];
    next_hrdata    = (addr_phase && !HWRITE) ? read_word(HADDR[7:0])
                                             : HRDATA;
    next_loaded    = loaded;
    next_prescale  = prescale;
    next_ratio     = ratio;
    next_sec       = sec;
    next_key_sel   = key_sel;
    next_acc_err   = acc_err;
    next_key_state = key_state;
    next_key_idx   = key_idx;
    next_cmd_start = 1'b0;
    // Software writes are applied first so hardware events below
    // override them in the same cycle.
    if (wr_pend) begin
      case (wr_addr)
        ADDR_CLOCK_DIVIDER: begin
          if (!loaded) begin
            next_loaded   = 1'b1;
            next_prescale = HWDATA[DIV_PRESCALE_BIT];
            next_ratio    = HWDATA[5:0];
          end
        end
        ADDR_CONFIGURATION: next_key_sel = HWDATA[CNFG_KEY_SEL_BIT];
        ADDR_STATUS: begin
          if (HWDATA[STAT_ERR_BIT]) begin
            next_acc_err = 1'b0;
          end
        end
        default: ;                  // Options are read-only
      endcase
    end
    // Setting key select opens a fresh comparison.
    if (!key_sel && next_key_sel) begin
      next_key_state = KEY_COLLECT;
      next_key_idx   = 4'h0;
    end
    // Array writes: key capture, else a program or erase attempt.
    if (ARRAY_WR) begin
      if (key_sel && in_key_window) begin
        if (key_src_ok && key_state == KEY_COLLECT) begin
          if (key_idx < KEY_BYTES &&
              ARRAY_ADDR[2:0] == key_idx[2:0] &&
              ARRAY_DATA == key_byte(NV_UNLOCK_KEY, key_idx[2:0])) begin
            next_key_idx = key_idx + 4'h1;
          end else begin
            next_key_state = KEY_FAIL;
          end
        end
      end else if (loaded) begin
        next_cmd_start = 1'b1;
      end else begin
        next_acc_err = 1'b1;
      end
    end
    // Clearing key select compares the collected bytes.
    if (key_sel && !next_key_sel) begin
      if (key_en && key_state == KEY_COLLECT &&
          key_idx == KEY_BYTES) begin
        next_sec = SEC_UNSECURED;
      end
      next_key_state = KEY_IDLE;
      next_key_idx   = 4'h0;
    end
    if (BLANK_CHECK_PASS) begin
      next_sec = SEC_UNSECURED;
    end
    next_secure    = next_sec != SEC_UNSECURED;
    next_mem_block = next_secure && MEM_SRC_UNSECURED;
  end

  // ***************************************************************
  // Registers
  // ***************************************************************
  // Reset reloads the working option and protection copies from the
  // stored bytes; only the security code changes after that, when a key
  // match or a blank check pass sets it to unsecured.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      wr_pend                 <= 1'b0;
      wr_addr                 <= 8'h00;
      HRDATA                  <= 32'h0000_0000;
      HREADYOUT               <= 1'b1;
      HRESP                   <= 1'b0;
      loaded                  <= 1'b0;
      prescale                <= 1'b0;
      ratio                   <= 6'h00;
      key_en                  <= NV_OPTION_BYTE[OPT_KEY_EN_BIT];
      redir_dis               <= NV_OPTION_BYTE[OPT_REDIR_DIS_BIT];
      sec                     <= NV_OPTION_BYTE[1:0];
      PROTECTION              <= NV_PROTECT_BYTE;
      VECTOR_REDIRECT_DISABLE <= NV_OPTION_BYTE[OPT_REDIR_DIS_BIT];
      SECURE                  <= NV_OPTION_BYTE[1:0] != SEC_UNSECURED;
      MEM_BLOCK               <= 1'b0;
      key_sel                 <= 1'b0;
      acc_err                 <= 1'b0;
      key_state               <= KEY_IDLE;
      key_idx                 <= 4'h0;
      CMD_START               <= 1'b0;
      PGM_ERASE_ALLOW         <= 1'b0;
    end else begin
      wr_pend                 <= next_wr_pend;
      wr_addr                 <= next_wr_addr;
      HRDATA                  <= next_hrdata;
      HREADYOUT               <= 1'b1;
      HRESP                   <= 1'b0;
      loaded                  <= next_loaded;
      prescale                <= next_prescale;
      ratio                   <= next_ratio;
      key_en                  <= key_en;
      redir_dis               <= redir_dis;
      sec                     <= next_sec;
      PROTECTION              <= PROTECTION;
      VECTOR_REDIRECT_DISABLE <= redir_dis;
      SECURE                  <= next_secure;
      MEM_BLOCK               <= next_mem_block;
      key_sel                 <= next_key_sel;
      acc_err                 <= next_acc_err;
      key_state               <= next_key_state;
      key_idx                 <= next_key_idx;
      CMD_START               <= next_cmd_start;
      PGM_ERASE_ALLOW         <= next_loaded;
    end
  end

  // ***************************************************************
  // Timing pulse generator
  // ***************************************************************
  // Held in reset until the divider is loaded, so no pulse ever uses
  // the unprogrammed ratio of zero.
  nv_clock_divider u_divider (
    .clk      (CLOCK),
    .rst      (RST),
    .enable   (loaded),
    .prescale (prescale),
    .ratio    (ratio),
    .tick     (NV_TICK)
  );

endmodule

/* File: logic/nv_clock_divider.sv */
// Purpose: Derives the nonvolatile timing pulse from the bus clock.
// Assumes: Settings are stable once the enable is high.
// Notes:   The tick is a one-cycle enable, never a real clock.
`timescale 1ns/1ps
module nv_clock_divider
  import flash_ctl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       enable,
  input  wire logic       prescale,
  input  wire logic [5:0] ratio,
  output logic            tick
);

  logic [2:0] pre_count;
  logic [5:0] main_count;
  logic [2:0] next_pre_count;
  logic [5:0] next_main_count;
  logic       next_tick;
  logic       step;

  // ***************************************************************
  // Prescale and main counters
  // ***************************************************************
  // The prescaler gives the divider one input step per bus cycle, or
  // one step every eight cycles; the main counter then divides by
  // ratio plus one, so each tick marks one timing period.
  always_comb begin
    next_pre_count  = pre_count;
    next_main_count = main_count;
    next_tick       = 1'b0;
    step            = 1'b0;
    if (enable) begin
      if (!prescale || pre_count == PRESCALE_LAST) begin
        step = 1'b1;
      end
      next_pre_count = prescale ? pre_count + 3'h1 : 3'h0;
      if (step) begin
        if (main_count == ratio) begin
          next_main_count = 6'h00;
          next_tick       = 1'b1;
        end else begin
          next_main_count = main_count + 6'h01;
        end
      end
    end else begin
      next_pre_count  = 3'h0;
      next_main_count = 6'h00;
    end
  end

  // Registers only; the sync reset parks the counters.
  always_ff @(posedge clk) begin
    if (rst) begin
      pre_count  <= 3'h0;
      main_count <= 6'h00;
      tick       <= 1'b0;
    end else begin
      pre_count  <= next_pre_count;
      main_count <= next_main_count;
      tick       <= next_tick;
    end
  end

endmodule

/* File: pkg/flash_ctl_pkg.sv */
// Purpose: Shared constants for the flash control register bank.
// Assumes: 50 MHz bus clock, AHB-Lite word-aligned register map.
// Notes:   Offsets are byte addresses of 32-bit words.
package flash_ctl_pkg;

  // ***************************************************************
  // Clock and nonvolatile timing figures
  // ***************************************************************
  localparam int unsigned CLOCK_HZ       = 50_000_000;
  localparam int unsigned NV_CLK_MIN_HZ  = 150_000;
  localparam int unsigned NV_CLK_MAX_HZ  = 200_000;
  localparam logic [2:0]  PRESCALE_LAST  = 3'h7;  // Divide by eight.

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [7:0] ADDR_CLOCK_DIVIDER = 8'h00;
  localparam logic [7:0] ADDR_OPTIONS       = 8'h04;
  localparam logic [7:0] ADDR_CONFIGURATION = 8'h08;
  localparam logic [7:0] ADDR_PROTECTION    = 8'h0c;
  localparam logic [7:0] ADDR_STATUS        = 8'h10;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int unsigned DIV_LOADED_BIT    = 7;
  localparam int unsigned DIV_PRESCALE_BIT  = 6;
  localparam int unsigned OPT_KEY_EN_BIT    = 7;
  localparam int unsigned OPT_REDIR_DIS_BIT = 6;
  localparam int unsigned CNFG_KEY_SEL_BIT  = 5;
  localparam int unsigned STAT_ERR_BIT      = 4;
  localparam int unsigned STAT_SECURE_BIT   = 0;

  // ***************************************************************
  // Security codes and key window
  // ***************************************************************
  localparam logic [1:0]  SEC_UNSECURED = 2'h2;
  localparam logic [15:0] KEY_BASE_ADDR = 16'hffb0;
  localparam logic [15:0] KEY_LAST_ADDR = 16'hffb7;
  localparam logic [3:0]  KEY_BYTES     = 4'h8;

  // Backdoor key comparison progress.
  typedef enum logic [1:0] {
    KEY_IDLE    = 2'b00,
    KEY_COLLECT = 2'b01,
    KEY_FAIL    = 2'b11
  } key_state_t;

endpackage

/* File: verif/flash_ctl_assertions.sv */
// Purpose: Concurrent checks on the flash control register ports.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes:   The stored option byte is held stable across each reset.
`timescale 1ns/1ps
module flash_ctl_assertions
  import flash_ctl_pkg::*;
(
  input wire logic       CLOCK,
  input wire logic       RST,
  input wire logic [7:0] NV_OPTION_BYTE,
  input wire logic       BLANK_CHECK_PASS,
  input wire logic       MEM_SRC_UNSECURED,
  input wire logic       CMD_START,
  input wire logic       PGM_ERASE_ALLOW,
  input wire logic       NV_TICK,
  input wire logic       SECURE,
  input wire logic       MEM_BLOCK,
  input wire logic       VECTOR_REDIRECT_DISABLE
);
  // ***************************************************************
  // Port relations
  // ***************************************************************
  // Every check runs on the bus clock and is muted while in reset.
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  chk_cmd_needs_load: assert property (CMD_START |-> PGM_ERASE_ALLOW)
    else $error("command started before divider load");
  chk_load_sticks: assert property (PGM_ERASE_ALLOW |=> PGM_ERASE_ALLOW)
    else $error("divider loaded flag dropped without reset");
  chk_tick_after_load: assert property (NV_TICK |-> PGM_ERASE_ALLOW)
    else $error("timing tick before divider load");
  chk_secure_code: assert property ($fell(RST) |->
    SECURE == (NV_OPTION_BYTE[1:0] != SEC_UNSECURED))
    else $error("security level does not follow stored code");
  chk_redirect_copy: assert property ($fell(RST) |->
    VECTOR_REDIRECT_DISABLE == NV_OPTION_BYTE[OPT_REDIR_DIS_BIT])
    else $error("redirect disable not loaded from stored byte");
  chk_unsecure_holds: assert property (!SECURE |=> !SECURE)
    else $error("device secured again without reset");
  chk_blank_unlock: assert property (BLANK_CHECK_PASS |->
    ##[1:2] !SECURE)
    else $error("blank check pass left device secure");
  chk_mem_blocking: assert property (!$past(RST) |->
    MEM_BLOCK == (SECURE && $past(MEM_SRC_UNSECURED)))
    else $error("memory block output wrong");
endmodule

/* File: verif/tb_top.sv */
// Purpose: Self-checking bench for the flash control register bank.
// Assumes: Zero-wait slave; HREADY is fed back from HREADYOUT.
// Notes:   Stored key byte i is 8'h11 times (i plus one).
`timescale 1ns/1ps
module tb_top
  import flash_ctl_pkg::*;
;
  logic        CLOCK, RST, HSEL, HWRITE, ARRAY_WR, ARRAY_SRC_SECURE;
  logic        ARRAY_SRC_DEBUG, BLANK_CHECK_PASS, MEM_SRC_UNSECURED;
  logic        HREADYOUT, HRESP, CMD_START, PGM_ERASE_ALLOW, NV_TICK;
  logic        SECURE, MEM_BLOCK, VECTOR_REDIRECT_DISABLE, c;
  logic [1:0]  HTRANS;
  logic [2:0]  HSIZE;
  logic [7:0]  NV_OPTION_BYTE, NV_PROTECT_BYTE, ARRAY_DATA, PROTECTION;
  logic [15:0] ARRAY_ADDR;
  logic [31:0] HADDR, HWDATA, HRDATA, rd;
  logic [63:0] NV_UNLOCK_KEY;
  int          err_total, n_compared, n;

  flash_control_registers i_dut (.CLOCK(CLOCK), .RST(RST), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
    .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .NV_OPTION_BYTE(NV_OPTION_BYTE),
    .NV_PROTECT_BYTE(NV_PROTECT_BYTE), .NV_UNLOCK_KEY(NV_UNLOCK_KEY),
    .ARRAY_WR(ARRAY_WR), .ARRAY_ADDR(ARRAY_ADDR), .ARRAY_DATA(ARRAY_DATA),
    .ARRAY_SRC_SECURE(ARRAY_SRC_SECURE), .ARRAY_SRC_DEBUG(ARRAY_SRC_DEBUG),
    .BLANK_CHECK_PASS(BLANK_CHECK_PASS), .MEM_SRC_UNSECURED(MEM_SRC_UNSECURED),
    .CMD_START(CMD_START), .PGM_ERASE_ALLOW(PGM_ERASE_ALLOW),
    .NV_TICK(NV_TICK), .SECURE(SECURE), .MEM_BLOCK(MEM_BLOCK),
    .VECTOR_REDIRECT_DISABLE(VECTOR_REDIRECT_DISABLE),
    .PROTECTION(PROTECTION));

  // ***************************************************************
  // Shared tasks
  // ***************************************************************
  // Compares one value and counts the outcome.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
    end
  endtask

  // One single-word transfer; read data is taken at the data-phase edge.
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [7:0] d, output logic [31:0] q);
    @(posedge CLOCK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= {24'h0, a};
    do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= {24'h0, d};
    do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
    q = HRDATA;
  endtask

  // One array write pulse; returns the command start seen after it.
  task automatic arr(input logic [15:0] a, input logic [7:0] d,
                     input logic s, input logic g, output logic q);
    @(posedge CLOCK);
    ARRAY_WR <= 1'b1;
    ARRAY_ADDR <= a;
    ARRAY_DATA <= d;
    ARRAY_SRC_SECURE <= s;
    ARRAY_SRC_DEBUG <= g;
    @(posedge CLOCK);
    ARRAY_WR <= 1'b0;
    #1 q = CMD_START;
  endtask

  // Resets with a given stored option byte, held for 16 cycles.
  task automatic rst_dut(input logic [7:0] opt);
    @(posedge CLOCK);
    RST <= 1'b1;
    NV_OPTION_BYTE <= opt;
    repeat (16) @(posedge CLOCK);
    RST <= 1'b0;
    @(posedge CLOCK);
    #1;
  endtask

  // Key entry with one byte spoilt at index bad; 8 spoils none.
  // A debug-port write in mid-sequence must leave the attempt intact.
  task automatic key_seq(input int bad);
    ahb(1'b1, ADDR_CONFIGURATION, 8'h20, rd);
    for (int k = 0; k < 8; k++) begin
      if (k == 4) begin
        arr(KEY_BASE_ADDR + 16'h4, 8'h00, 1'b1, 1'b1, c);
        arr(KEY_BASE_ADDR + 16'h4, 8'h00, 1'b0, 1'b0, c);
      end
      arr(KEY_BASE_ADDR + 16'(k), (k == bad) ? 8'h00 : 8'(17 * (k + 1)),
          1'b1, 1'b0, c);
      check(32'(c), 32'h0);
    end
    ahb(1'b1, ADDR_CONFIGURATION, 8'h00, rd);
    @(posedge CLOCK);
    #1;
  endtask

  // Counts cycles from one timing tick to the next.
  task automatic period(output int p);
    p = 0;
    for (int w = 0; w < 400 && NV_TICK !== 1'b1; w++) begin
      @(posedge CLOCK);
      #1;
    end
    do begin
      @(posedge CLOCK);
      #1;
      p++;
    end while (NV_TICK !== 1'b1 && p < 400);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  // Values after reset, refused writes and an early array write.
  task automatic t_reset();
    ahb(1'b0, ADDR_OPTIONS, 8'h00, rd);
    check(rd, 32'h81);
    check(32'(HRESP), 32'h0);
    ahb(1'b1, ADDR_OPTIONS, 8'h42, rd);
    ahb(1'b0, ADDR_OPTIONS, 8'h00, rd);
    check(rd, 32'h81);
    check(32'(PROTECTION), 32'h5a);
    check(32'(SECURE), 32'h1);
    check(32'(VECTOR_REDIRECT_DISABLE), 32'h0);
    ahb(1'b0, ADDR_CLOCK_DIVIDER, 8'h00, rd);
    check(rd, 32'h0);
    arr(16'h8000, 8'h55, 1'b1, 1'b0, c);
    check(32'(c), 32'h0);
    ahb(1'b0, ADDR_STATUS, 8'h00, rd);
    check(rd, 32'h11);
    ahb(1'b1, ADDR_STATUS, 8'h10, rd);
    ahb(1'b0, ADDR_STATUS, 8'h00, rd);
    check(rd, 32'h01);
    ahb(1'b0, 8'h40, 8'h00, rd);
    check(rd, 32'h0);
    MEM_SRC_UNSECURED <= 1'b1;
    repeat (2) @(posedge CLOCK);
    #1 check(32'(MEM_BLOCK), 32'h1);
  endtask

  // Write-once divider with prescale; tick every 8 * (32 + 1) cycles.
  // That gives about 189 kHz from 50 MHz, inside the legal band.
  task automatic t_divider();
    ahb(1'b1, ADDR_CLOCK_DIVIDER, 8'h60, rd);
    ahb(1'b1, ADDR_CLOCK_DIVIDER, 8'h03, rd);
    ahb(1'b0, ADDR_CLOCK_DIVIDER, 8'h00, rd);
    check(rd, 32'he0);
    check(32'(PGM_ERASE_ALLOW), 32'h1);
    arr(16'h8000, 8'h55, 1'b1, 1'b0, c);
    check(32'(c), 32'h1);
    arr(KEY_BASE_ADDR, 8'h55, 1'b1, 1'b0, c);
    check(32'(c), 32'h1);
    period(n);
    check(32'(n), 32'd264);
  endtask

  // A spoilt key keeps security; a good one lifts it until reset.
  task automatic t_unlock();
    ahb(1'b1, ADDR_CONFIGURATION, 8'hff, rd);
    ahb(1'b0, ADDR_CONFIGURATION, 8'h00, rd);
    check(rd, 32'h20);
    key_seq(3);
    check(32'(SECURE), 32'h1);
    key_seq(8);
    check(32'(SECURE), 32'h0);
    check(32'(MEM_BLOCK), 32'h0);
    ahb(1'b0, ADDR_OPTIONS, 8'h00, rd);
    check(rd, 32'h82);
  endtask

  // Key disabled: a good key is refused, a blank check still unlocks.
  task automatic t_locked();
    rst_dut(8'h7c);
    check(32'(SECURE), 32'h1);
    check(32'(VECTOR_REDIRECT_DISABLE), 32'h1);
    key_seq(8);
    check(32'(SECURE), 32'h1);
    ahb(1'b1, ADDR_CLOCK_DIVIDER, 8'h04, rd);
    period(n);
    check(32'(n), 32'd5);
    @(posedge CLOCK);
    BLANK_CHECK_PASS <= 1'b1;
    @(posedge CLOCK);
    BLANK_CHECK_PASS <= 1'b0;
    @(posedge CLOCK);
    #1 check(32'(SECURE), 32'h0);
  endtask

  // ***************************************************************
  // Clock, sequence and watchdog
  // ***************************************************************
  // Bus clock of 50 MHz.
  initial begin
    CLOCK = 1'b0;
    forever #10 CLOCK = ~CLOCK;
  end

  // Inputs get values at time zero, then the scenarios run in turn.
  initial begin
    {HSEL, HWRITE, ARRAY_WR, ARRAY_SRC_SECURE, ARRAY_SRC_DEBUG} = '0;
    {BLANK_CHECK_PASS, MEM_SRC_UNSECURED, HTRANS, HADDR, HWDATA} = '0;
    {ARRAY_ADDR, ARRAY_DATA, err_total, n_compared} = '0;
    HSIZE = 3'h2;
    RST = 1'b1;
    NV_OPTION_BYTE = 8'hbd;
    NV_PROTECT_BYTE = 8'h5a;
    NV_UNLOCK_KEY = 64'h8877665544332211;
    rst_dut(8'hbd);
    t_reset();
    t_divider();
    t_unlock();
    t_locked();
    test_done();
  end

  // The whole run needs well under 2000 cycles; a hang ends here.
  initial begin
    repeat (20000) @(posedge CLOCK);
    err_total++;
    test_done();
  end
endmodule

bind flash_control_registers flash_ctl_assertions i_chk (.CLOCK(CLOCK),
  .RST(RST), .NV_OPTION_BYTE(NV_OPTION_BYTE),
  .BLANK_CHECK_PASS(BLANK_CHECK_PASS), .MEM_SRC_UNSECURED(MEM_SRC_UNSECURED),
  .CMD_START(CMD_START), .PGM_ERASE_ALLOW(PGM_ERASE_ALLOW),
  .NV_TICK(NV_TICK), .SECURE(SECURE), .MEM_BLOCK(MEM_BLOCK),
  .VECTOR_REDIRECT_DISABLE(VECTOR_REDIRECT_DISABLE));
